// >>> core/cad_defines.vh
// Constants for the CPU arithmetic and status datapath
`ifndef CAD_DEFINES_VH
`define CAD_DEFINES_VH

// ALU operation codes
`define CAD_OP_ADD      4'h0
`define CAD_OP_ADDC     4'h1
`define CAD_OP_SUB      4'h2
`define CAD_OP_SUBB     4'h3
`define CAD_OP_AND      4'h4
`define CAD_OP_IOR      4'h5
`define CAD_OP_XOR      4'h6
`define CAD_OP_ASR      4'h7
`define CAD_OP_SHL      4'h8
`define CAD_OP_LSR      4'h9
`define CAD_OP_MOV      4'ha
`define CAD_OP_NOP      4'hf

// Multiplier modes
`define CAD_MUL_SS      3'h0
`define CAD_MUL_UU      3'h1
`define CAD_MUL_SU5     3'h2
`define CAD_MUL_UU5     3'h3
`define CAD_MUL_US      3'h4
`define CAD_MUL_SU      3'h5
`define CAD_MUL_UU8     3'h6

// Flag update mask bit positions (also status bit positions)
`define CAD_C_BIT       0
`define CAD_Z_BIT       1
`define CAD_OV_BIT      2
`define CAD_N_BIT       3
`define CAD_RA_BIT      4
`define CAD_IPL_LO      5
`define CAD_IPL_HI      7
`define CAD_DC_BIT      8

// Control register bit positions
`define CAD_PWE_BIT     2
`define CAD_IPLM_BIT    3

// Table page bit that opens configuration space
`define CAD_TBLPG_CFG   7

// Top program address bit
`define CAD_PADDR_TOP   23

// Reset values
`define CAD_FLAGS_RST   16'h0000
`define CAD_CTRL_RST    16'h0000

// Divide timing
`define CAD_DIV_CYCLES  5'h13
`define CAD_DIV_ITERS   5'h10

`endif

// >>> core/cad_shifter.v
// Single-cycle barrel shifter for arithmetic right, logic right and left shifts
`timescale 1ns/1ps
`default_nettype none
`include "cad_defines.vh"

module cad_shifter #(
  parameter WIDTH = 16
) (
  input  wire [WIDTH-1:0] data_in,
  input  wire [3:0]       amount_in,
  input  wire [1:0]       kind_in,
  output reg  [WIDTH-1:0] result_out,
  output reg              carry_out
);
  // kind: 0 arithmetic right, 1 left, 2 logic right
  reg [2*WIDTH-1:0] wide;

  always @* begin
    wide       = {2*WIDTH{1'b0}};
    result_out = {WIDTH{1'b0}};
    carry_out  = 1'b0;
    case (kind_in)
      2'h0: begin
        wide       = $signed({data_in, {WIDTH{1'b0}}}) >>> amount_in;
        result_out = wide[2*WIDTH-1:WIDTH];
        carry_out  = (amount_in == 4'h0) ? 1'b0 : wide[WIDTH-1];
      end
      2'h1: begin
        wide       = {{WIDTH{1'b0}}, data_in} << amount_in;
        result_out = wide[WIDTH-1:0];
        carry_out  = (amount_in == 4'h0) ? 1'b0 : wide[WIDTH];
      end
      2'h2: begin
        wide       = {data_in, {WIDTH{1'b0}}} >> amount_in;
        result_out = wide[2*WIDTH-1:WIDTH];
        carry_out  = (amount_in == 4'h0) ? 1'b0 : wide[WIDTH-1];
      end
      default: begin
        result_out = data_in;
      end
    endcase
  end
endmodule // cad_shifter

`default_nettype wire

// >>> core/cad_divider.v
// Iterative restoring divider, one step per divisor bit
`timescale 1ns/1ps
`default_nettype none
`include "cad_defines.vh"

module cad_divider (
  input  wire        mclk_in,
  input  wire        rstn_in,
  input  wire        start_in,
  input  wire        hold_in,
  input  wire        signed_in,
  input  wire        long_in,
  input  wire [31:0] dividend_in,
  input  wire [15:0] divisor_in,
  output reg  [15:0] quot_out,
  output reg  [15:0] rem_out,
  output reg         busy_out,
  output reg         done_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_FIX  = 2'h2;

  reg [1:0]  state_r;
  reg [4:0]  cnt_r;
  reg [31:0] num_r;
  reg [16:0] part_r;
  reg [15:0] den_r;
  reg        qneg_r;
  reg        rneg_r;
  reg [31:0] dvd_abs;
  reg [15:0] dvs_abs;
  reg [16:0] trial;
  reg [15:0] q_fix;
  reg [15:0] r_fix;

  always @* begin
    dvd_abs = long_in ? dividend_in : (signed_in ? {{16{dividend_in[15]}}, dividend_in[15:0]}
                                                  : {16'h0000, dividend_in[15:0]});
    if (signed_in && dvd_abs[31])
      dvd_abs = 32'h0 - dvd_abs;
    dvs_abs = (signed_in && divisor_in[15]) ? 16'h0 - divisor_in : divisor_in;
    trial   = {part_r[15:0], num_r[31]} - {1'b0, den_r};
    q_fix   = qneg_r ? 16'h0 - num_r[15:0] : num_r[15:0];
    r_fix   = rneg_r ? 16'h0 - part_r[15:0] : part_r[15:0];
  end

  // Interrupt hold freezes the sequence at any cycle boundary
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 5'h00;
      num_r    <= 32'h0;
      part_r   <= 17'h0;
      den_r    <= 16'h0;
      qneg_r   <= 1'b0;
      rneg_r   <= 1'b0;
      quot_out <= 16'h0;
      rem_out  <= 16'h0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_in) begin
            num_r    <= {dvd_abs[15:0], 16'h0};
            part_r   <= {1'b0, dvd_abs[31:16]};
            den_r    <= dvs_abs;
            qneg_r   <= signed_in & ((long_in ? dividend_in[31] : dividend_in[15]) ^ divisor_in[15]);
            rneg_r   <= signed_in & (long_in ? dividend_in[31] : dividend_in[15]);
            cnt_r    <= `CAD_DIV_CYCLES - 5'h1;
            busy_out <= 1'b1;
            state_r  <= ST_RUN;
          end
        end
        ST_RUN: if (!hold_in) begin
          cnt_r <= cnt_r - 5'h1;
          if (cnt_r >= `CAD_DIV_CYCLES - `CAD_DIV_ITERS) begin
            if (!trial[16]) begin
              part_r <= trial;
              num_r  <= {num_r[30:0], 1'b1};
            end else begin
              part_r <= {part_r[15:0], num_r[31]};
              num_r  <= {num_r[30:0], 1'b0};
            end
          end
          if (cnt_r == 5'h2)
            state_r <= ST_FIX;
        end
        ST_FIX: if (!hold_in) begin
          quot_out <= q_fix;
          rem_out  <= r_fix;
          busy_out <= 1'b0;
          done_out <= 1'b1;
          state_r  <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // cad_divider

`default_nettype wire

// >>> core/cad_alu_core.v
// CPU arithmetic datapath with status and control registers
`timescale 1ns/1ps
`default_nettype none
`include "cad_defines.vh"

module cad_alu_core #(
  parameter WIDTH = 16
) (
  input  wire             mclk_in,
  input  wire             rstn_in,
  input  wire             op_valid_in,
  input  wire [3:0]       op_code_in,
  input  wire             byte_mode_in,
  input  wire [8:0]       flag_mask_in,
  input  wire [WIDTH-1:0] opa_in,
  input  wire [WIDTH-1:0] opb_in,
  input  wire [3:0]       shift_amt_in,
  input  wire             shift_src_reg_in,
  input  wire             mul_valid_in,
  input  wire [2:0]       mul_mode_in,
  input  wire [4:0]       mul_lit_in,
  input  wire             div_start_in,
  input  wire             div_signed_in,
  input  wire             div_long_in,
  input  wire [31:0]      dividend_in,
  input  wire [WIDTH-1:0] divisor_in,
  input  wire             irq_hold_in,
  input  wire             repeat_busy_in,
  input  wire             nesting_disable_in,
  input  wire             hw_prio_we_in,
  input  wire [3:0]       hw_prio_in,
  input  wire             flags_we_in,
  input  wire             ctrl_we_in,
  input  wire [WIDTH-1:0] wdata_in,
  input  wire             pfetch_valid_in,
  input  wire [23:0]      paddr_in,
  input  wire             ptable_in,
  input  wire [7:0]       table_page_in,
  output reg  [WIDTH-1:0] result_out,
  output reg              result_valid_out,
  output reg              result_to_wreg_out,
  output reg  [31:0]      product_out,
  output reg              product_valid_out,
  output reg  [WIDTH-1:0] quotient_out,
  output reg  [WIDTH-1:0] remainder_out,
  output reg              div_busy_out,
  output reg              div_done_out,
  output reg  [WIDTH-1:0] alu_flags_out,
  output reg  [WIDTH-1:0] cpu_control_out,
  output reg  [3:0]       eff_priority_out,
  output reg              user_irq_block_out,
  output reg              prog_window_out,
  output reg              paddr_ok_out
);
  // Status and control storage
  reg       dc_r, n_r, ov_r, z_r, c_r, ra_r;
  reg [2:0] ipl_r;
  reg       iplm_r;
  reg       pwe_r;
  reg       dc_nxt, n_nxt, ov_nxt, z_nxt, c_nxt;
  reg [2:0] ipl_nxt;
  reg       iplm_nxt;

  // All inputs share mclk_in
  reg [WIDTH-1:0] res;
  reg [WIDTH:0]   sum;
  reg [4:0]       lo_sum;
  reg [8:0]       mid_sum;
  reg [WIDTH-1:0] b_eff;
  reg             cin;
  reg             is_arith;
  reg             is_sub;
  reg             cy, hc, ovf, neg, zero;
  reg [1:0]       sh_kind;
  reg [16:0]      ma, mb;
  reg signed [33:0] mprod;

  wire [WIDTH-1:0] sh_res;
  wire             sh_cy;
  wire [WIDTH-1:0] div_q;
  wire [WIDTH-1:0] div_r;
  wire             div_busy;
  wire             div_done;

  // Byte results are masked to the low half
  function [WIDTH-1:0] size_mask;
    input [WIDTH-1:0] v;
    input             bm;
    begin
      size_mask = bm ? {{(WIDTH-8){1'b0}}, v[7:0]} : v;
    end
  endfunction

  function msb_of;
    input [WIDTH-1:0] v;
    input             bm;
    begin
      msb_of = bm ? v[7] : v[WIDTH-1];
    end
  endfunction

  always @* begin
    case (op_code_in)
      `CAD_OP_ASR: sh_kind = 2'h0;
      `CAD_OP_SHL: sh_kind = 2'h1;
      `CAD_OP_LSR: sh_kind = 2'h2;
      default:     sh_kind = 2'h3;
    endcase
  end

  cad_shifter #(
    .WIDTH (WIDTH)
  ) u_shift (
    .data_in    (size_mask(opa_in, byte_mode_in)),
    .amount_in  (shift_amt_in),
    .kind_in    (sh_kind),
    .result_out (sh_res),
    .carry_out  (sh_cy)
  );

  cad_divider u_div (
    .mclk_in     (mclk_in),
    .rstn_in     (rstn_in),
    .start_in    (div_start_in),
    .hold_in     (irq_hold_in),
    .signed_in   (div_signed_in),
    .long_in     (div_long_in),
    .dividend_in (dividend_in),
    .divisor_in  (divisor_in),
    .quot_out    (div_q),
    .rem_out     (div_r),
    .busy_out    (div_busy),
    .done_out    (div_done)
  );

  // Arithmetic and logic
  always @* begin
    is_sub   = (op_code_in == `CAD_OP_SUB) || (op_code_in == `CAD_OP_SUBB);
    is_arith = is_sub || (op_code_in == `CAD_OP_ADD) || (op_code_in == `CAD_OP_ADDC);
    b_eff    = size_mask(is_sub ? ~opb_in : opb_in, byte_mode_in);
    case (op_code_in)
      `CAD_OP_SUB:  cin = 1'b1;
      `CAD_OP_ADDC: cin = c_r;
      `CAD_OP_SUBB: cin = c_r;
      default:      cin = 1'b0;
    endcase
    sum     = {1'b0, size_mask(opa_in, byte_mode_in)} + {1'b0, b_eff} + {{WIDTH{1'b0}}, cin};
    lo_sum  = {1'b0, opa_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    mid_sum = {1'b0, opa_in[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
    hc      = byte_mode_in ? lo_sum[4] : mid_sum[8];
    cy      = byte_mode_in ? sum[8] : sum[WIDTH];
    case (op_code_in)
      `CAD_OP_AND: res = opa_in & opb_in;
      `CAD_OP_IOR: res = opa_in | opb_in;
      `CAD_OP_XOR: res = opa_in ^ opb_in;
      `CAD_OP_MOV: res = opa_in;
      `CAD_OP_ASR, `CAD_OP_SHL, `CAD_OP_LSR: res = sh_res;
      default:     res = sum[WIDTH-1:0];
    endcase
    if (sh_kind != 2'h3) begin
      cy = sh_cy;
      if (byte_mode_in && sh_kind == 2'h0 && shift_amt_in != 4'h0)
        res = sh_res;
    end
    res  = size_mask(res, byte_mode_in);
    neg  = msb_of(res, byte_mode_in);
    zero = (res == {WIDTH{1'b0}});
    ovf  = is_arith & (msb_of(opa_in, byte_mode_in) == msb_of(b_eff, byte_mode_in))
           & (msb_of(opa_in, byte_mode_in) != neg);
  end

  // Flag next state; mask selects which flags this op affects
  always @* begin
    dc_nxt   = dc_r;
    n_nxt    = n_r;
    ov_nxt   = ov_r;
    z_nxt    = z_r;
    c_nxt    = c_r;
    ipl_nxt  = ipl_r;
    iplm_nxt = iplm_r;
    if (flags_we_in) begin
      dc_nxt = wdata_in[`CAD_DC_BIT];
      n_nxt  = wdata_in[`CAD_N_BIT];
      ov_nxt = wdata_in[`CAD_OV_BIT];
      z_nxt  = wdata_in[`CAD_Z_BIT];
      c_nxt  = wdata_in[`CAD_C_BIT];
      if (!nesting_disable_in)
        ipl_nxt = wdata_in[`CAD_IPL_HI:`CAD_IPL_LO];
    end
    if (op_valid_in) begin
      if (flag_mask_in[`CAD_DC_BIT]) dc_nxt = hc;
      if (flag_mask_in[`CAD_N_BIT])  n_nxt  = neg;
      if (flag_mask_in[`CAD_OV_BIT]) ov_nxt = ovf;
      if (flag_mask_in[`CAD_C_BIT])  c_nxt  = cy;
      // Extended ops only clear zero, never set it
      if (flag_mask_in[`CAD_Z_BIT])
        z_nxt = ((op_code_in == `CAD_OP_ADDC) || (op_code_in == `CAD_OP_SUBB)) ?
                (z_r & zero) : zero;
    end
    if (ctrl_we_in && !wdata_in[`CAD_IPLM_BIT])
      iplm_nxt = 1'b0;
    if (hw_prio_we_in) begin
      ipl_nxt  = hw_prio_in[2:0];
      iplm_nxt = hw_prio_in[3];
    end
  end

  always @* begin
    ma = {17{1'b0}};
    mb = {17{1'b0}};
    case (mul_mode_in)
      `CAD_MUL_SS:  begin ma = {opa_in[15], opa_in}; mb = {opb_in[15], opb_in}; end
      `CAD_MUL_UU:  begin ma = {1'b0, opa_in};       mb = {1'b0, opb_in};       end
      `CAD_MUL_SU5: begin ma = {opa_in[15], opa_in}; mb = {12'h000, mul_lit_in}; end
      `CAD_MUL_UU5: begin ma = {1'b0, opa_in};       mb = {12'h000, mul_lit_in}; end
      `CAD_MUL_US:  begin ma = {1'b0, opa_in};       mb = {opb_in[15], opb_in}; end
      `CAD_MUL_SU:  begin ma = {opa_in[15], opa_in}; mb = {1'b0, opb_in};       end
      `CAD_MUL_UU8: begin ma = {9'h000, opa_in[7:0]}; mb = {9'h000, opb_in[7:0]}; end
      default:      ;
    endcase
    mprod = $signed(ma) * $signed(mb);
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dc_r <= 1'b0; n_r <= 1'b0; ov_r <= 1'b0; z_r <= 1'b0; c_r <= 1'b0; ra_r <= 1'b0;
      ipl_r  <= 3'h0;
      iplm_r <= 1'b0;
      pwe_r  <= 1'b0;
      result_out         <= {WIDTH{1'b0}};
      result_valid_out   <= 1'b0;
      result_to_wreg_out <= 1'b0;
      product_out        <= 32'h0;
      product_valid_out  <= 1'b0;
      quotient_out       <= {WIDTH{1'b0}};
      remainder_out      <= {WIDTH{1'b0}};
      div_busy_out       <= 1'b0;
      div_done_out       <= 1'b0;
      alu_flags_out      <= `CAD_FLAGS_RST;
      cpu_control_out    <= `CAD_CTRL_RST;
      eff_priority_out   <= 4'h0;
      user_irq_block_out <= 1'b0;
      prog_window_out    <= 1'b0;
      paddr_ok_out       <= 1'b0;
    end else begin
      dc_r   <= dc_nxt;
      n_r    <= n_nxt;
      ov_r   <= ov_nxt;
      z_r    <= z_nxt;
      c_r    <= c_nxt;
      ra_r   <= repeat_busy_in;
      ipl_r  <= ipl_nxt;
      iplm_r <= iplm_nxt;
      if (ctrl_we_in)
        pwe_r <= wdata_in[`CAD_PWE_BIT];
      result_out         <= res;
      result_valid_out   <= op_valid_in;
      // Multi-bit shifts always return to a working register
      result_to_wreg_out <= op_valid_in & ((sh_kind != 2'h3) | shift_src_reg_in);
      product_out        <= (mul_mode_in == `CAD_MUL_UU8) ? {16'h0000, mprod[15:0]}
                                                          : mprod[31:0];
      product_valid_out  <= mul_valid_in;
      if (div_done) begin
        quotient_out  <= div_q;
        remainder_out <= div_r;
      end
      div_busy_out <= div_busy;
      div_done_out <= div_done;
      alu_flags_out <= {7'h00, dc_nxt, ipl_nxt, repeat_busy_in,
                        n_nxt, ov_nxt, z_nxt, c_nxt};
      cpu_control_out <= {12'h000, iplm_nxt,
                          ctrl_we_in ? wdata_in[`CAD_PWE_BIT] : pwe_r, 2'h0};
      eff_priority_out   <= {iplm_nxt, ipl_nxt};
      user_irq_block_out <= iplm_nxt | (ipl_nxt == 3'h7);
      prog_window_out    <= ctrl_we_in ? wdata_in[`CAD_PWE_BIT] : pwe_r;
      // Upper half reachable only by table ops with the config page bit
      paddr_ok_out <= pfetch_valid_in & (~paddr_in[`CAD_PADDR_TOP] |
                      (ptable_in & table_page_in[`CAD_TBLPG_CFG]));
    end
  end
endmodule // cad_alu_core

`default_nettype wire

// >>> verification/cad_alu_core_properties.sv
// Port checker for the CPU arithmetic and status datapath
`timescale 1ns/1ps
`default_nettype none
module cad_alu_props #(
  parameter WIDTH = 16
) (
  input wire logic             mclk_in,
  input wire logic             rstn_in,
  input wire logic             op_valid_in,
  input wire logic [8:0]       flag_mask_in,
  input wire logic             mul_valid_in,
  input wire logic             div_start_in,
  input wire logic             irq_hold_in,
  input wire logic             repeat_busy_in,
  input wire logic             nesting_disable_in,
  input wire logic             hw_prio_we_in,
  input wire logic             flags_we_in,
  input wire logic             ctrl_we_in,
  input wire logic             pfetch_valid_in,
  input wire logic [23:0]      paddr_in,
  input wire logic             ptable_in,
  input wire logic [7:0]       table_page_in,
  input wire logic             result_valid_out,
  input wire logic             product_valid_out,
  input wire logic             div_busy_out,
  input wire logic             div_done_out,
  input wire logic [WIDTH-1:0] alu_flags_out,
  input wire logic [WIDTH-1:0] cpu_control_out,
  input wire logic [3:0]       eff_priority_out,
  input wire logic             user_irq_block_out,
  input wire logic             prog_window_out,
  input wire logic             paddr_ok_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  logic [5:0] div_age_r;
  logic [5:0] div_hold_r;
  wire        paddr_exp = pfetch_valid_in & (~paddr_in[23] | (ptable_in & table_page_in[7]));
  // Cycles since start, less held ones
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_age_r  <= 6'h00;
      div_hold_r <= 6'h00;
    end else if (div_start_in && !div_busy_out) begin
      div_age_r  <= 6'h01;
      div_hold_r <= 6'h00;
    end else if (div_age_r != 6'h3f) begin
      div_age_r  <= div_age_r + 6'h01;
      div_hold_r <= div_hold_r + {5'h00, irq_hold_in};
    end
  end
  AST_RES_VALID: assert property (result_valid_out == $past(op_valid_in))
    else $error("result valid late");
  AST_MUL_VALID: assert property (product_valid_out == $past(mul_valid_in))
    else $error("product valid late");
  AST_UNIMPL_ZERO: assert property (alu_flags_out[15:9] == 7'h00 &&
    cpu_control_out[15:4] == 12'h000 && cpu_control_out[1:0] == 2'h0)
    else $error("unimplemented bit set");
  AST_EFF_PRIO: assert property (eff_priority_out == {cpu_control_out[3], alu_flags_out[7:5]})
    else $error("priority wrong");
  AST_IRQ_BLOCK: assert property (user_irq_block_out == (cpu_control_out[3] | &alu_flags_out[7:5]))
    else $error("irq block wrong");
  AST_PWIN: assert property (prog_window_out == cpu_control_out[2])
    else $error("window wrong");
  AST_REPEAT: assert property (alu_flags_out[4] == $past(repeat_busy_in))
    else $error("repeat bit wrong");
  AST_PADDR: assert property (paddr_ok_out == $past(paddr_exp))
    else $error("paddr wrong");
  AST_DIV_DONE: assert property (div_done_out |-> (div_age_r - div_hold_r) == 6'h14)
    else $error("divide done late");
  AST_DIV_BUSY: assert property ((div_start_in && !div_busy_out) |-> ##3 div_busy_out)
    else $error("divider not busy");
  AST_ZERO_KEEP: assert property ((op_valid_in && !flag_mask_in[1] && !flags_we_in)
    |=> $stable(alu_flags_out[1])) else $error("zero flag changed");
  AST_NEST_RO: assert property ((nesting_disable_in && !hw_prio_we_in)
    |=> $stable(alu_flags_out[7:5])) else $error("priority not read-only");
  AST_MSB_SW: assert property ((ctrl_we_in && !hw_prio_we_in && !cpu_control_out[3])
    |=> !cpu_control_out[3]) else $error("msb set by write");
endmodule // cad_alu_props
bind cad_alu_core cad_alu_props #(.WIDTH(WIDTH)) u_props (.*);
`default_nettype wire

// >>> verification/cad_wreg_model.sv
// Working register file model capturing results the datapath writes back
`timescale 1ns/1ps
`default_nettype none
module cad_wreg_model (
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        res_valid_in,
  input  wire logic        res_wreg_in,
  input  wire logic [15:0] res_in,
  input  wire logic        div_done_in,
  input  wire logic [15:0] quot_in,
  input  wire logic [15:0] rem_in,
  output var  logic [15:0] w0_out,
  output var  logic [15:0] w1_out,
  output var  logic [15:0] wlast_out
);
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      w0_out    <= 16'h0000;
      w1_out    <= 16'h0000;
      wlast_out <= 16'h0000;
    end else begin
      if (div_done_in) begin
        w0_out <= quot_in;
        w1_out <= rem_in;
      end
      // Only register-destined results may land here
      if (res_valid_in && res_wreg_in) begin
        wlast_out <= res_in;
      end
    end
  end
endmodule // cad_wreg_model
`default_nettype wire

// >>> verification/cpu_alu_status_datapath_bench.sv
// Self-checking bench for the CPU arithmetic and status datapath
`timescale 1ns/1ps
`default_nettype none
`include "cad_defines.vh"
module cpu_alu_status_datapath_bench;
  logic        mclk_in = 1'b0, rstn_in = 1'b0, op_valid_in = 1'b0, byte_mode_in = 1'b0;
  logic        shift_src_reg_in = 1'b0, mul_valid_in = 1'b0, div_start_in = 1'b0;
  logic        div_signed_in = 1'b0, div_long_in = 1'b0, irq_hold_in = 1'b0;
  logic        repeat_busy_in = 1'b0, nesting_disable_in = 1'b0, hw_prio_we_in = 1'b0;
  logic        flags_we_in = 1'b0, ctrl_we_in = 1'b0, pfetch_valid_in = 1'b0, ptable_in = 1'b0;
  logic [3:0]  op_code_in = 4'h0, shift_amt_in = 4'h0, hw_prio_in = 4'h0;
  logic [8:0]  flag_mask_in = 9'h000;
  logic [2:0]  mul_mode_in = 3'h0;
  logic [4:0]  mul_lit_in = 5'h03;
  logic [7:0]  table_page_in = 8'h00;
  logic [23:0] paddr_in = 24'h000000;
  logic [31:0] dividend_in = 32'h00000000;
  logic [15:0] opa_in = 16'h0000, opb_in = 16'h0000, divisor_in = 16'h0001, wdata_in = 16'h0000;
  logic [15:0] result_out, quotient_out, remainder_out, alu_flags_out, cpu_control_out;
  logic [15:0] w0, w1, wlast;
  logic [31:0] product_out;
  logic [3:0]  eff_priority_out;
  logic        result_valid_out, result_to_wreg_out, product_valid_out, div_busy_out;
  logic        div_done_out, user_irq_block_out, prog_window_out, paddr_ok_out;
  int          n_mismatch = 0, tests_run = 0, cyc = 0;

  cad_alu_core #(.WIDTH(16)) dut_u (.*);
  cad_wreg_model wreg_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .res_valid_in(result_valid_out),
    .res_wreg_in(result_to_wreg_out), .res_in(result_out), .div_done_in(div_done_out),
    .quot_in(quotient_out), .rem_in(remainder_out), .w0_out(w0), .w1_out(w1), .wlast_out(wlast));

  always #12.5 mclk_in = ~mclk_in;
  // Only a hang reaches this
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end

  task automatic test_done;
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic alu(input logic [3:0] c, input logic bm, input logic [8:0] m,
                     input logic [15:0] a, b, input logic [3:0] s, input logic [15:0] er, ef);
    @(posedge mclk_in);
    op_valid_in  <= 1'b1;
    op_code_in   <= c;
    byte_mode_in <= bm;
    flag_mask_in <= m;
    opa_in       <= a;
    opb_in       <= b;
    shift_amt_in <= s;
    @(posedge mclk_in);
    op_valid_in <= 1'b0;
    @(negedge mclk_in);
    chk("result", 32'(er), 32'(result_out));
    chk("flags", 32'(ef), 32'(alu_flags_out));
  endtask

  task automatic wr(input logic ctl, input logic [15:0] d, input logic [15:0] ef, ec);
    @(posedge mclk_in);
    flags_we_in <= ~ctl;
    ctrl_we_in  <= ctl;
    wdata_in    <= d;
    @(posedge mclk_in);
    flags_we_in <= 1'b0;
    ctrl_we_in  <= 1'b0;
    @(negedge mclk_in);
    chk("flags reg", 32'(ef), 32'(alu_flags_out));
    chk("ctrl reg", 32'(ec), 32'(cpu_control_out));
  endtask

  task automatic t_arith;
    alu(`CAD_OP_ADD, 1'b0, 9'h10f, 16'h7fff, 16'h0001, 4'h0, 16'h8000, 16'h010c);
    alu(`CAD_OP_ADD, 1'b1, 9'h10f, 16'h000f, 16'h0001, 4'h0, 16'h0010, 16'h0100);
    alu(`CAD_OP_ADD, 1'b0, 9'h10f, 16'hffff, 16'h0001, 4'h0, 16'h0000, 16'h0103);
    alu(`CAD_OP_ADDC, 1'b0, 9'h001, 16'h0001, 16'h0001, 4'h0, 16'h0003, 16'h0102);
    alu(`CAD_OP_SUBB, 1'b0, 9'h001, 16'h0005, 16'h0002, 4'h0, 16'h0002, 16'h0103);
    alu(`CAD_OP_SUB, 1'b0, 9'h10f, 16'h0000, 16'h0001, 4'h0, 16'hffff, 16'h0008);
    alu(`CAD_OP_AND, 1'b0, 9'h002, 16'h00f0, 16'h000f, 4'h0, 16'h0000, 16'h000a);
    alu(`CAD_OP_XOR, 1'b0, 9'h002, 16'h0001, 16'h0000, 4'h0, 16'h0001, 16'h0008);
    alu(`CAD_OP_IOR, 1'b0, 9'h000, 16'h00f0, 16'h000f, 4'h0, 16'h00ff, 16'h0008);
    alu(`CAD_OP_SUB, 1'b1, 9'h10f, 16'h0010, 16'h0001, 4'h0, 16'h000f, 16'h0001);
  endtask

  task automatic t_shift;
    alu(`CAD_OP_ASR, 1'b0, 9'h000, 16'h8000, 16'h0000, 4'h1, 16'hc000, 16'h0001);
    alu(`CAD_OP_ASR, 1'b0, 9'h000, 16'h8000, 16'h0000, 4'hf, 16'hffff, 16'h0001);
    alu(`CAD_OP_SHL, 1'b0, 9'h000, 16'h0001, 16'h0000, 4'hf, 16'h8000, 16'h0001);
    alu(`CAD_OP_LSR, 1'b0, 9'h000, 16'h8000, 16'h0000, 4'hf, 16'h0001, 16'h0001);
    @(negedge mclk_in);
    chk("wreg write", 32'h00000001, 32'(wlast));
  endtask

  task automatic t_mul;
    logic [31:0] ex [7];
    ex = '{32'h00000002, 32'hfffd0002, 32'hfffffffd, 32'h0002fffd,
           32'hfffe0002, 32'hffff0002, 32'h0000fd02};
    @(posedge mclk_in);
    mul_valid_in <= 1'b1;
    mul_mode_in  <= 3'h0;
    opa_in       <= 16'hffff;
    opb_in       <= 16'hfffe;
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk_in);
      if (i < 6) mul_mode_in <= 3'(i + 1);
      else mul_valid_in <= 1'b0;
      @(negedge mclk_in);
      chk("product", ex[i], product_out);
    end
  endtask

  task automatic t_div(input logic sg, lg, input logic [31:0] dd, input logic [15:0] dv,
                       input logic [15:0] eq, erm, input int hold);
    int n;
    @(posedge mclk_in);
    div_start_in  <= 1'b1;
    div_signed_in <= sg;
    div_long_in   <= lg;
    dividend_in   <= dd;
    divisor_in    <= dv;
    @(posedge mclk_in);
    div_start_in <= 1'b0;
    n = 0;
    while (n < 60) begin
      @(negedge mclk_in);
      if (div_done_out === 1'b1) break;
      @(posedge mclk_in);
      n++;
      if (n == 5 && hold > 0) irq_hold_in <= 1'b1;
      if (n == 5 + hold) irq_hold_in <= 1'b0;
      // A start while busy must be ignored
      if (n == 8) div_start_in <= 1'b1;
      if (n == 9) div_start_in <= 1'b0;
    end
    chk("div latency", 32'(`CAD_DIV_CYCLES) + 32'(hold), 32'(n));
    chk("quotient", 32'(eq), 32'(quotient_out));
    chk("remainder", 32'(erm), 32'(remainder_out));
    @(negedge mclk_in);
    chk("w0", 32'(eq), 32'(w0));
    chk("w1", 32'(erm), 32'(w1));
  endtask

  task automatic t_status;
    wr(1'b0, 16'hffff, 16'h01ef, 16'h0000);
    chk("eff prio", 32'h7, 32'(eff_priority_out));
    chk("irq block", 32'h1, 32'(user_irq_block_out));
    nesting_disable_in <= 1'b1;
    wr(1'b0, 16'h0000, 16'h00e0, 16'h0000);
    nesting_disable_in <= 1'b0;
    @(posedge mclk_in);
    hw_prio_we_in <= 1'b1;
    hw_prio_in    <= 4'ha;
    @(posedge mclk_in);
    hw_prio_we_in <= 1'b0;
    @(negedge mclk_in);
    chk("hw flags", 32'h0040, 32'(alu_flags_out));
    chk("hw ctrl", 32'h0008, 32'(cpu_control_out));
    chk("eff prio", 32'ha, 32'(eff_priority_out));
    wr(1'b1, 16'h0004, 16'h0040, 16'h0004);
    chk("window", 32'h1, 32'(prog_window_out));
    wr(1'b1, 16'hfffb, 16'h0040, 16'h0000);
    repeat_busy_in <= 1'b1;
    wr(1'b0, 16'h0000, 16'h0010, 16'h0000);
    repeat_busy_in <= 1'b0;
    wr(1'b0, 16'h0000, 16'h0000, 16'h0000);
  endtask

  task automatic t_paddr;
    logic [23:0] ad [4];
    logic [3:0]  tb, pg, ok;
    ad = '{24'h7fffff, 24'h800000, 24'h800000, 24'h800000};
    tb = 4'b0110;
    pg = 4'b0010;
    ok = 4'b0011;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_in);
      pfetch_valid_in <= 1'b1;
      paddr_in        <= ad[i];
      ptable_in       <= tb[i];
      table_page_in   <= {pg[i], 7'h00};
      @(posedge mclk_in);
      pfetch_valid_in <= 1'b0;
      @(negedge mclk_in);
      chk("paddr ok", 32'(ok[i]), 32'(paddr_ok_out));
    end
  endtask

  initial begin
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(negedge mclk_in);
    chk("reset flags", 32'h0, 32'(alu_flags_out));
    chk("reset ctrl", 32'h0, 32'(cpu_control_out));
    t_arith;
    t_shift;
    t_mul;
    t_div(1'b0, 1'b1, 32'h00010005, 16'h0002, 16'h8002, 16'h0001, 0);
    t_div(1'b1, 1'b0, 32'h0000fff9, 16'h0002, 16'hfffd, 16'hffff, 3);
    t_div(1'b1, 1'b1, 32'hfffffff9, 16'h0002, 16'hfffd, 16'hffff, 0);
    t_div(1'b0, 1'b0, 32'h0000ffff, 16'h0010, 16'h0fff, 16'h000f, 0);
    t_status;
    t_paddr;
    test_done;
  end
endmodule // cpu_alu_status_datapath_bench
`default_nettype wire
